/* File: common/pmrc_defines.svh */
`ifndef PMRC_DEFINES_SVH
`define PMRC_DEFINES_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PMRC_OFF_CONTROL    12'h000
`define PMRC_OFF_CMD        12'h004
`define PMRC_OFF_ALERT      12'h008
`define PMRC_OFF_STATUS     12'h00C
`define PMRC_OFF_ACTIVE     12'h010
`define PMRC_OFF_BUS_VOLTAGE_RESULT       12'h014
`define PMRC_OFF_SENSE_VOLTAGE_RESULT     12'h018
`define PMRC_OFF_POWER_PRODUCT_RESULT     12'h01C
`define PMRC_OFF_ACC_LO     12'h020
`define PMRC_OFF_ACC_HI     12'h024
`define PMRC_OFF_COUNT      12'h028
`define PMRC_OFF_ADC_BUS    12'h02C
`define PMRC_OFF_ADC_SENSE  12'h030
// ----------------------------------------
// Control fields
// ----------------------------------------
`define PMRC_CTL_MODE_LSB   0
`define PMRC_CTL_AUTO_LSB   4
`define PMRC_CTL_PIN0_LSB   6
`define PMRC_CTL_PIN1_LSB   8
`define PMRC_CTL_RESET      10'h0C2
`define PMRC_PIN_ALERT      2'h0
`define PMRC_PIN_SLOW       2'h3
// ----------------------------------------
// Command codes
// ----------------------------------------
`define PMRC_CMD_REFRESH    2'h1
`define PMRC_CMD_REFRESH_G  2'h2
`define PMRC_CMD_REFRESH_V  2'h3
// ----------------------------------------
// Sample modes and timing
// ----------------------------------------
`define PMRC_MODE_8         4'h5
`define PMRC_MODE_64        4'h4
`define PMRC_MODE_256       4'h3
`define PMRC_MODE_1024      4'h2
`define PMRC_MODE_4096      4'h1
`define PMRC_MODE_8192      4'h0
`define PMRC_MODE_SLEEP_A   4'hE
`define PMRC_MODE_SLEEP_B   4'hF
`define PMRC_CLK_MHZ        100
`define PMRC_T_UPDATE_NS    1000
`define PMRC_UPDATE_CYC     ((`PMRC_T_UPDATE_NS * `PMRC_CLK_MHZ) / 1000)
`define PMRC_SPS_8          8
`define PMRC_SPS_64         64
`define PMRC_SPS_256        256
`define PMRC_SPS_1024       1024
`define PMRC_SPS_4096       4096
`define PMRC_SPS_8192       8192
`define PMRC_SAMPLE_CYC     200
`endif

/* File: common/pmrc_pkg.sv */
package pmrc_pkg;
  typedef enum logic [2:0] {
    PMRC_SLEEP,
    PMRC_SAMPLE_BUS,
    PMRC_SAMPLE_SENSE,
    PMRC_MULTIPLY,
    PMRC_IDLE
  } pmrc_state_e;
  typedef logic [11:0] pmrc_sample_t;
  typedef logic [9:0]  pmrc_ctl_t;
endpackage

/* File: src/pmrc_top.sv */
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "pmrc_defines.svh"
// Notes on behaviour
// - Cycle length is one over sample rate.
// - One 12-bit converter, bus then sense.
// - Multiply bus by sense each cycle.
// - Publish 1 us after running cycle ends.
// - Active after reset, sample, multiply, accumulate.
// - Default 1024 sps, host may change.
// - Slow pin high forces 8 sps.
// - Idle for rest of cycle below max.
// - Refresh publishes and clears accumulator, count.
// - New control applies only after refresh.
// - Published data frozen until next refresh.
// - Refresh never restarts the sampling sequence.
// - Unpublished cycle results are simply discarded.
// - General refresh equals plain refresh.
// - Addressed general refresh acts only here.
// - Refresh-V publishes, keeps accumulator and count.
// - Auto-refresh publishes data every cycle only.
// - Auto-refresh ignores manual refresh unless control clears auto field.
// - Auto-refresh overwrites unread data.
// - Auto-refresh halts while control differs from active.
// - Conversion-done alert needs pin, enable, route.
// - Sleep modes entered by refresh, left likewise.
module pmrc_top
  import pmrc_pkg::*;
#(
  parameter int CLK_HZ   = 100_000_000,
  parameter int ACC_W    = 56,
  parameter int CNT_W    = 32
) (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST,
  input  wire logic [11:0] I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  input  wire logic [11:0] I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  input  wire logic [11:0] I_ADC_BUS,
  input  wire logic [11:0] I_ADC_SENSE,
  input  wire logic        I_PIN0_IN,
  input  wire logic        I_PIN1_IN,
  input  wire logic        I_GCALL_REFRESH,
  output logic             O_ADC_SAMPLE,
  output logic             O_ADC_SEL_SENSE,
  output logic             O_PIN0_OE,
  output logic             O_PIN1_OE,
  output logic             O_SLEEPING
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  localparam int UPD_CYC = `PMRC_UPDATE_CYC;

  function automatic logic [23:0] cycle_len(input logic [3:0] mode);
    int sps;
    case (mode)
      `PMRC_MODE_8:    sps = `PMRC_SPS_8;
      `PMRC_MODE_64:   sps = `PMRC_SPS_64;
      `PMRC_MODE_256:  sps = `PMRC_SPS_256;
      `PMRC_MODE_4096: sps = `PMRC_SPS_4096;
      `PMRC_MODE_8192: sps = `PMRC_SPS_8192;
      default:         sps = `PMRC_SPS_1024;
    endcase
    cycle_len = 24'(CLK_HZ / sps);
  endfunction

  function automatic logic is_sleep(input logic [3:0] mode);
    is_sleep = (mode == `PMRC_MODE_SLEEP_A) || (mode == `PMRC_MODE_SLEEP_B);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  pmrc_ctl_t         ctl_q, ctl_d, act_q, act_d;
  logic [2:0]        alert_q, alert_d;
  pmrc_state_e       st_q, st_d;
  logic [23:0]       tmr_q, tmr_d, len_q, len_d;
  pmrc_sample_t      vb_q, vb_d, vs_q, vs_d;
  logic [23:0]       pw_q, pw_d;
  logic [ACC_W-1:0]  acc_q, acc_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  pmrc_sample_t      pvb_q, pvb_d, pvs_q, pvs_d;
  logic [23:0]       ppw_q, ppw_d;
  logic [ACC_W-1:0]  pacc_q, pacc_d;
  logic [CNT_W-1:0]  pcnt_q, pcnt_d;
  logic              pend_q, pend_d, clr_q, clr_d, cfg_q, cfg_d;
  logic [7:0]        upd_q, upd_d;
  logic              updating_q, updating_d, udclr_q, udclr_d, udcfg_q, udcfg_d;
  logic              done_q, done_d, pin0_q, pin0_d, pin1_q, pin1_d;
  logic              smp_q, smp_d, sel_q, sel_d;
  logic              slp_q, slp_d;
  logic              awr_q, awr_d, wr_q, wr_d, bv_q, bv_d;
  logic              arr_q, arr_d, rv_q, rv_d;
  logic [31:0]       rd_q, rd_d;
  logic              cycle_end, slow_forced, do_wr, do_rd;
  logic [1:0]        cmd;

  // ----------------------------------------
  // Bus and command logic
  // ----------------------------------------
  always_comb begin
    do_wr = I_AWVALID && I_WVALID && !bv_q && !awr_q;
    do_rd = I_ARVALID && !rv_q && !arr_q;
    awr_d = do_wr;
    wr_d  = do_wr;
    bv_d  = bv_q ? !I_BREADY : do_wr;
    arr_d = do_rd;
    rv_d  = rv_q ? !I_RREADY : do_rd;
    ctl_d = ctl_q;
    alert_d = alert_q;
    cmd = 2'h0;
    if (do_wr && I_WSTRB[0]) begin
      case (I_AWADDR)
        `PMRC_OFF_CONTROL: ctl_d = I_WDATA[9:0];
        `PMRC_OFF_ALERT:   alert_d = I_WDATA[2:0];
        `PMRC_OFF_CMD:     cmd = I_WDATA[1:0];
        default:           ;
      endcase
    end
    rd_d = rd_q;
    if (do_rd) begin
      case (I_ARADDR)
        `PMRC_OFF_CONTROL:   rd_d = {22'h0, ctl_q};
        `PMRC_OFF_ALERT:     rd_d = {29'h0, alert_q};
        `PMRC_OFF_STATUS:    rd_d = {29'h0, pend_q, st_q == PMRC_SLEEP, done_q};
        `PMRC_OFF_ACTIVE:    rd_d = {22'h0, act_q};
        `PMRC_OFF_BUS_VOLTAGE_RESULT:      rd_d = {20'h0, pvb_q};
        `PMRC_OFF_SENSE_VOLTAGE_RESULT:    rd_d = {20'h0, pvs_q};
        `PMRC_OFF_POWER_PRODUCT_RESULT:    rd_d = {8'h0, ppw_q};
        `PMRC_OFF_ACC_LO:    rd_d = pacc_q[31:0];
        `PMRC_OFF_ACC_HI:    rd_d = 32'(pacc_q[ACC_W-1:32]);
        `PMRC_OFF_COUNT:     rd_d = 32'(pcnt_q);
        `PMRC_OFF_ADC_BUS:   rd_d = {20'h0, vb_q};
        `PMRC_OFF_ADC_SENSE: rd_d = {20'h0, vs_q};
        default:             rd_d = 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  always_comb begin
    logic auto_on, manual_ok;
    auto_on = act_q[`PMRC_CTL_AUTO_LSB +: 2] != 2'h0;
    manual_ok = !auto_on || (ctl_q[`PMRC_CTL_AUTO_LSB +: 2] == 2'h0);
    // Slow pin on either pin 0 or pin 1 forces the slow rate
    slow_forced = (act_q[`PMRC_CTL_PIN0_LSB +: 2] == `PMRC_PIN_SLOW && I_PIN0_IN) ||
                  (act_q[`PMRC_CTL_PIN1_LSB +: 2] == `PMRC_PIN_SLOW && I_PIN1_IN);
    cycle_end = (st_q == PMRC_IDLE || st_q == PMRC_MULTIPLY) && tmr_q >= len_q - 24'h1;
    st_d = st_q;
    tmr_d = (st_q == PMRC_SLEEP) ? 24'h0 : tmr_q + 24'h1;
    len_d = len_q;
    vb_d = vb_q;
    vs_d = vs_q;
    pw_d = pw_q;
    acc_d = acc_q;
    cnt_d = cnt_q;
    smp_d = 1'b0;
    sel_d = sel_q;
    case (st_q)
      PMRC_SAMPLE_BUS: begin
        smp_d = 1'b1;
        sel_d = 1'b0;
        if (tmr_q == 24'(`PMRC_SAMPLE_CYC)) begin
          vb_d = I_ADC_BUS;
          st_d = PMRC_SAMPLE_SENSE;
        end
      end
      PMRC_SAMPLE_SENSE: begin
        smp_d = 1'b1;
        sel_d = 1'b1;
        if (tmr_q == 24'(2 * `PMRC_SAMPLE_CYC)) begin
          vs_d = I_ADC_SENSE;
          st_d = PMRC_MULTIPLY;
        end
      end
      PMRC_MULTIPLY: begin
        pw_d = 24'(vb_q) * 24'(vs_q);
        acc_d = acc_q + ACC_W'(pw_d);
        cnt_d = cnt_q + 1'b1;
        st_d = PMRC_IDLE;
      end
      PMRC_IDLE: ;
      PMRC_SLEEP: ;
      default: st_d = PMRC_SLEEP;
    endcase
    pend_d = pend_q;
    clr_d = clr_q;
    cfg_d = cfg_q;
    updating_d = updating_q;
    upd_d = upd_q;
    udclr_d = udclr_q;
    udcfg_d = udcfg_q;
    act_d = act_q;
    done_d = 1'b0;
    if (cycle_end || (st_q == PMRC_SLEEP && pend_q)) begin
      done_d = st_q != PMRC_SLEEP;
      tmr_d = 24'h0;
      st_d = is_sleep(act_q[3:0]) ? PMRC_SLEEP : PMRC_SAMPLE_BUS;
      len_d = slow_forced ? cycle_len(`PMRC_MODE_8) : cycle_len(act_q[3:0]);
      if (pend_q) begin
        updating_d = 1'b1;
        upd_d = 8'h0;
        udclr_d = clr_q;
        udcfg_d = cfg_q;
        pend_d = 1'b0;
        clr_d = 1'b0;
        cfg_d = 1'b0;
      end else if (auto_on && ctl_q == act_q && st_q != PMRC_SLEEP) begin
        updating_d = 1'b1;
        upd_d = 8'h0;
        udclr_d = 1'b0;
        udcfg_d = 1'b0;
      end
    end
    // Manual refresh, with general-call path; a new request wins over the clear
    if (cmd != 2'h0 || I_GCALL_REFRESH) begin
      if (manual_ok) begin
        pend_d = 1'b1;
        cfg_d = 1'b1;
        clr_d = clr_d || (cmd != `PMRC_CMD_REFRESH_V);
      end
    end
    if (updating_q) begin
      upd_d = upd_q + 8'h1;
      if (upd_q == 8'(UPD_CYC - 1)) begin
        updating_d = 1'b0;
        pvb_d = vb_q;
        pvs_d = vs_q;
        ppw_d = pw_q;
        pacc_d = acc_q;
        pcnt_d = cnt_q;
        if (udclr_q) begin
          acc_d = '0;
          cnt_d = '0;
        end
        if (udcfg_q) begin
          act_d = ctl_q;
          if (is_sleep(ctl_q[3:0])) st_d = PMRC_SLEEP;
          else if (st_q == PMRC_SLEEP) begin
            st_d = PMRC_SAMPLE_BUS;
            tmr_d = 24'h0;
            len_d = cycle_len(ctl_q[3:0]);
          end
        end
      end else begin
        pvb_d = pvb_q;
        pvs_d = pvs_q;
        ppw_d = ppw_q;
        pacc_d = pacc_q;
        pcnt_d = pcnt_q;
      end
    end else begin
      pvb_d = pvb_q;
      pvs_d = pvs_q;
      ppw_d = ppw_q;
      pacc_d = pacc_q;
      pcnt_d = pcnt_q;
    end
    // Open-drain alert: low from conversion done, cleared by a STATUS read
    pin0_d = pin0_q;
    pin1_d = pin1_q;
    if (done_q) begin
      pin0_d = alert_q[0] && alert_q[1] &&
               act_q[`PMRC_CTL_PIN0_LSB +: 2] == `PMRC_PIN_ALERT;
      pin1_d = alert_q[0] && alert_q[2] &&
               act_q[`PMRC_CTL_PIN1_LSB +: 2] == `PMRC_PIN_ALERT;
    end else if (do_rd && I_ARADDR == `PMRC_OFF_STATUS) begin
      pin0_d = 1'b0;
      pin1_d = 1'b0;
    end
    slp_d = (st_d == PMRC_SLEEP);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      ctl_q <= `PMRC_CTL_RESET;
      act_q <= `PMRC_CTL_RESET;
      alert_q <= 3'h0;
      st_q <= PMRC_SAMPLE_BUS;
      tmr_q <= 24'h0;
      len_q <= 24'(CLK_HZ / `PMRC_SPS_1024);
      {vb_q, vs_q, pw_q, pvb_q, pvs_q, ppw_q} <= '0;
      {acc_q, pacc_q, cnt_q, pcnt_q} <= '0;
      {pend_q, clr_q, cfg_q, updating_q, udclr_q, udcfg_q} <= '0;
      upd_q <= 8'h0;
      {done_q, pin0_q, pin1_q, smp_q, sel_q} <= '0;
      slp_q <= 1'b0;
      {awr_q, wr_q, bv_q, arr_q, rv_q} <= '0;
      rd_q <= 32'h0;
    end else begin
      ctl_q <= ctl_d;
      act_q <= act_d;
      alert_q <= alert_d;
      st_q <= st_d;
      tmr_q <= tmr_d;
      len_q <= len_d;
      {vb_q, vs_q, pw_q, pvb_q, pvs_q, ppw_q} <= {vb_d, vs_d, pw_d, pvb_d, pvs_d, ppw_d};
      {acc_q, pacc_q, cnt_q, pcnt_q} <= {acc_d, pacc_d, cnt_d, pcnt_d};
      {pend_q, clr_q, cfg_q, updating_q, udclr_q, udcfg_q} <=
        {pend_d, clr_d, cfg_d, updating_d, udclr_d, udcfg_d};
      upd_q <= upd_d;
      {done_q, pin0_q, pin1_q, smp_q, sel_q} <= {done_d, pin0_d, pin1_d, smp_d, sel_d};
      slp_q <= slp_d;
      {awr_q, wr_q, bv_q, arr_q, rv_q} <= {awr_d, wr_d, bv_d, arr_d, rv_d};
      rd_q <= rd_d;
    end
  end

  assign O_AWREADY = awr_q;
  assign O_WREADY = wr_q;
  assign O_BVALID = bv_q;
  assign O_BRESP = 2'h0;
  assign O_ARREADY = arr_q;
  assign O_RVALID = rv_q;
  assign O_RDATA = rd_q;
  assign O_RRESP = 2'h0;
  assign O_ADC_SAMPLE = smp_q;
  assign O_ADC_SEL_SENSE = sel_q;
  assign O_PIN0_OE = pin0_q;
  assign O_PIN1_OE = pin1_q;
  assign O_SLEEPING = slp_q;
endmodule

/* File: verif/pmrc_assertions.sv */
`timescale 1ns/100ps
module pmrc_checker #(
  parameter int CLK_HZ = 100_000_000
) (
  input wire logic        I_CORE_CLK,
  input wire logic        I_RST,
  input wire logic        I_ARVALID,
  input wire logic        I_BREADY,
  input wire logic        I_RREADY,
  input wire logic        O_AWREADY,
  input wire logic        O_WREADY,
  input wire logic [1:0]  O_BRESP,
  input wire logic        O_BVALID,
  input wire logic        O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic [1:0]  O_RRESP,
  input wire logic        O_RVALID,
  input wire logic        O_ADC_SAMPLE,
  input wire logic        O_ADC_SEL_SENSE,
  input wire logic        O_SLEEPING
);
  // ----
  // Cycle length tracker, default rate
  // ----
  localparam int PER = CLK_HZ / 1024;
  logic [31:0] gap_q, gap_d;
  logic        seen_q, seen_d, smp_q, rise;
  always_comb begin
    rise   = O_ADC_SAMPLE & ~smp_q;
    gap_d  = rise ? 32'h1 : gap_q + 32'h1;
    seen_d = O_SLEEPING ? 1'b0 : (rise | seen_q);
  end
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      gap_q  <= '0;
      seen_q <= 1'b0;
      smp_q  <= 1'b0;
    end else begin
      gap_q  <= gap_d;
      seen_q <= seen_d;
      smp_q  <= O_ADC_SAMPLE;
    end
  end
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  // ----
  // Properties
  // ----
  AST_CYCLE_LEN: assert property (rise && seen_q |-> gap_q == PER)
    else $error("conversion cycle length wrong");
  AST_BUS_FIRST: assert property ($rose(O_ADC_SAMPLE) |-> !O_ADC_SEL_SENSE)
    else $error("sense sampled before bus");
  AST_IDLE_REST: assert property ($fell(O_ADC_SAMPLE) |=> !O_ADC_SAMPLE [*8])
    else $error("no idle after sampling");
  AST_SLEEP_QUIET: assert property (O_SLEEPING && $past(O_SLEEPING) |-> !O_ADC_SAMPLE)
    else $error("sampling while asleep");
  AST_WR_ANSWER: assert property (O_AWREADY |-> O_WREADY && O_BVALID ##1 !O_AWREADY)
    else $error("write answer wrong");
  AST_B_HOLD: assert property (O_BVALID && !I_BREADY |=> O_BVALID && O_BRESP == 2'h0)
    else $error("write response dropped");
  AST_RD_ANSWER: assert property ($rose(I_ARVALID) && !O_RVALID |=> O_ARREADY && O_RVALID)
    else $error("read answer late");
  AST_R_HOLD: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data not held");
  AST_R_OKAY: assert property (O_RVALID |-> O_RRESP == 2'h0 ##1 !O_ARREADY)
    else $error("read response wrong");
endmodule
bind pmrc_top pmrc_checker #(.CLK_HZ(CLK_HZ)) u_chk (
  .I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_ARVALID(I_ARVALID), .I_BREADY(I_BREADY),
  .I_RREADY(I_RREADY), .O_AWREADY(O_AWREADY), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP),
  .O_BVALID(O_BVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP),
  .O_RVALID(O_RVALID), .O_ADC_SAMPLE(O_ADC_SAMPLE), .O_ADC_SEL_SENSE(O_ADC_SEL_SENSE),
  .O_SLEEPING(O_SLEEPING));

/* File: verif/pmrc_far_model.sv */
`timescale 1ns/100ps
module pmrc_far_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_sample,
  input  wire logic        i_sel_sense,
  input  wire logic        i_fire,
  input  wire logic [11:0] i_bus_val,
  input  wire logic [11:0] i_sense_val,
  output logic [11:0]      o_adc_bus,
  output logic [11:0]      o_adc_sense,
  output logic             o_gcall
);
  // Result valid only in its own phase
  always_comb begin
    o_adc_bus   = (i_sample && !i_sel_sense) ? i_bus_val : ~i_bus_val;
    o_adc_sense = (i_sample && i_sel_sense) ? i_sense_val : ~i_sense_val;
  end
  // One-cycle general-call refresh
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_gcall <= 1'b0;
    else o_gcall <= i_fire;
  end
endmodule

/* File: verif/power_monitor_refresh_control_tb_top.sv */
`timescale 1ns/100ps
`include "pmrc_defines.svh"
module power_monitor_refresh_control_tb_top;
  localparam int HZ  = 2_048_000;
  localparam int PER = HZ / 1024;
  localparam int PUB = PER + 200;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, fire, gcall, pin0, smp_prev;
  logic        awready, wready, bvalid, arready, rvalid, smp, sel, oe0, oe1, slp;
  logic [11:0] awaddr, araddr, bus_val, sense_val, adc_bus, adc_sense;
  logic [31:0] wdata, rdata, p, c1, c2;
  logic [1:0]  bresp, rresp;
  int          errors, cmp_count, rises;
  always #5 clk = ~clk;
  pmrc_top #(.CLK_HZ(HZ)) i_dut (
    .I_CORE_CLK(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid),
    .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_ADC_BUS(adc_bus),
    .I_ADC_SENSE(adc_sense), .I_PIN0_IN(pin0), .I_PIN1_IN(1'b0), .I_GCALL_REFRESH(gcall),
    .O_ADC_SAMPLE(smp), .O_ADC_SEL_SENSE(sel), .O_PIN0_OE(oe0), .O_PIN1_OE(oe1),
    .O_SLEEPING(slp));
  pmrc_far_model i_far (
    .i_clk(clk), .i_rst(rst), .i_sample(smp), .i_sel_sense(sel), .i_fire(fire),
    .i_bus_val(bus_val), .i_sense_val(sense_val), .o_adc_bus(adc_bus),
    .o_adc_sense(adc_sense), .o_gcall(gcall));
  // ----
  // Bus and check tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (!bready && (bvalid || $urandom_range(1))) bready <= 1'b1;
    end while (!(bvalid && bready) && n < 1000);
    bready <= 1'b0;
    if (n >= 1000) errors++;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (!rready && (rvalid || $urandom_range(1))) rready <= 1'b1;
    end while (!(rvalid && rready) && n < 1000);
    d = rdata;
    rready <= 1'b0;
    if (n >= 1000) errors++;
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(nm, d, exp);
  endtask
  task automatic cmd(input logic [1:0] c);
    wr(`PMRC_OFF_CMD, {30'h0, c});
    repeat (PUB) @(posedge clk);
  endtask
  task automatic newvals;
    bus_val   <= 12'($urandom) & 12'h7FF;
    sense_val <= 12'($urandom) & 12'h7FF;
    repeat (2 * PER) @(posedge clk);
  endtask
  function automatic logic [31:0] pw(input logic [11:0] b, input logic [11:0] s);
    return 32'(b) * 32'(s);
  endfunction
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----
  // Watchdog
  // ----
  initial begin
    repeat (90_000) @(posedge clk);
    errors++;
    final_report;
  end
  // ----
  // Main sequence
  // ----
  initial begin
    {clk, awvalid, wvalid, bready, arvalid, rready, fire, pin0} = '0;
    {awaddr, araddr, wdata, bus_val, sense_val} = '0;
    rst = 1'b1;
    errors = 0;
    cmp_count = 0;
    void'($urandom(50));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rchk("control", `PMRC_OFF_CONTROL, 32'h0C2);
    rchk("unmapped", 12'hFFC, 32'h0);
    newvals;
    cmd(`PMRC_CMD_REFRESH);
    rchk("bus_voltage_result", `PMRC_OFF_BUS_VOLTAGE_RESULT, {20'h0, bus_val});
    rchk("sense_voltage_result", `PMRC_OFF_SENSE_VOLTAGE_RESULT, {20'h0, sense_val});
    rchk("power_product_result", `PMRC_OFF_POWER_PRODUCT_RESULT, pw(bus_val, sense_val));
    p = {20'h0, bus_val};
    newvals;
    rchk("bus_voltage_result frozen", `PMRC_OFF_BUS_VOLTAGE_RESULT, p);
    cmd(`PMRC_CMD_REFRESH);
    cmd(`PMRC_CMD_REFRESH_V);
    rd(`PMRC_OFF_COUNT, c1);
    rchk("acc", `PMRC_OFF_ACC_LO, c1 * pw(bus_val, sense_val));
    repeat (PER) @(posedge clk);
    cmd(`PMRC_CMD_REFRESH_V);
    rd(`PMRC_OFF_COUNT, c2);
    chk("count kept", 32'(c2 > c1), 32'h1);
    cmd(`PMRC_CMD_REFRESH);
    cmd(`PMRC_CMD_REFRESH_V);
    rd(`PMRC_OFF_COUNT, c1);
    chk("count cleared", 32'(c1 < c2), 32'h1);
    rchk("acc cleared", `PMRC_OFF_ACC_LO, c1 * pw(bus_val, sense_val));
    newvals;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (PUB) @(posedge clk);
    rchk("gcall bus_voltage_result", `PMRC_OFF_BUS_VOLTAGE_RESULT, {20'h0, bus_val});
    newvals;
    cmd(`PMRC_CMD_REFRESH_G);
    rchk("cmd g bus_voltage_result", `PMRC_OFF_BUS_VOLTAGE_RESULT, {20'h0, bus_val});
    for (int m = 14; m < 16; m++) begin
      wr(`PMRC_OFF_CONTROL, 32'h0C0 | 32'(m));
      rchk("active held", `PMRC_OFF_ACTIVE, 32'h0C2);
      cmd(`PMRC_CMD_REFRESH);
      rchk("active new", `PMRC_OFF_ACTIVE, 32'h0C0 | 32'(m));
      chk("sleeping", 32'(slp), 32'h1);
      rchk("bus_voltage_result kept", `PMRC_OFF_BUS_VOLTAGE_RESULT, {20'h0, bus_val});
      wr(`PMRC_OFF_CONTROL, 32'h0C2);
      cmd(`PMRC_CMD_REFRESH);
      chk("awake", 32'(slp), 32'h0);
    end
    wr(`PMRC_OFF_CONTROL, 32'h0D2);
    cmd(`PMRC_CMD_REFRESH);
    newvals;
    rchk("auto bus_voltage_result", `PMRC_OFF_BUS_VOLTAGE_RESULT, {20'h0, bus_val});
    p = {20'h0, bus_val};
    wr(`PMRC_OFF_CONTROL, 32'h1D2);
    cmd(`PMRC_CMD_REFRESH);
    newvals;
    rchk("auto halted", `PMRC_OFF_BUS_VOLTAGE_RESULT, p);
    rchk("refresh ignored", `PMRC_OFF_ACTIVE, 32'h0D2);
    wr(`PMRC_OFF_CONTROL, 32'h0C2);
    cmd(`PMRC_CMD_REFRESH);
    rchk("auto off", `PMRC_OFF_ACTIVE, 32'h0C2);
    wr(`PMRC_OFF_ALERT, 32'h5);
    cmd(`PMRC_CMD_REFRESH);
    chk("alert pin1", 32'(oe1), 32'h1);
    chk("alert pin0", 32'(oe0), 32'h0);
    rd(`PMRC_OFF_STATUS, c1);
    repeat (2) @(posedge clk);
    chk("alert cleared", 32'(oe1), 32'h0);
    // Slow pin high: next cycle runs at the slow rate
    pin0 <= 1'b1;
    repeat (PER) @(posedge clk);
    rises = 0;
    smp_prev = smp;
    repeat (2 * PER) begin
      @(posedge clk);
      if (smp && !smp_prev) rises++;
      smp_prev = smp;
    end
    chk("slow rate", 32'(rises <= 1), 32'h1);
    final_report;
  end
endmodule
